// ===== pkg/ctci_params.svh
// Register map, field positions, reset values and divider settings of the compare timer
`ifndef CTCI_PARAMS_SVH
`define CTCI_PARAMS_SVH

// Register indexes; the byte address on the bus is four times the index
`define CTCI_IDX_CTRL_ONE  8'h14
`define CTCI_IDX_CTRL_TWO  8'h15
`define CTCI_IDX_COMPARE   8'h16
`define CTCI_IDX_STATUS    8'h17

// Field positions in timer_control_one
`define CTCI_C1_RUN        0
`define CTCI_C1_SSRC       1
`define CTCI_C1_BOTH       2
`define CTCI_C1_EDGE       3
`define CTCI_C1_CYCLE      4
`define CTCI_C1_MODE       5
`define CTCI_C1_POL        6
`define CTCI_C1_SRES       7

// Field positions in timer_control_two
`define CTCI_C2_FFINIT     0
`define CTCI_C2_CLK_LO     1
`define CTCI_C2_CLK_HI     3
`define CTCI_C2_CNT_LO     4
`define CTCI_C2_CNT_HI     5
`define CTCI_C2_TDIS       6

// Field positions in the status word
`define CTCI_ST_RUNNING    0
`define CTCI_ST_FLOP       1
`define CTCI_ST_CNT_LO     16

// Reset values
`define CTCI_CTRL_RST      1'b0
`define CTCI_CLK_RST       3'h0
`define CTCI_CNT_SEL_RST   2'h0
`define CTCI_COMPARE_RST   16'hffff
`define CTCI_COUNT_RST     16'h0000

// Clock source and compare count codes
`define CTCI_CLK_EVENT     3'h7
`define CTCI_CNT_TWO       2'h1
`define CTCI_CNT_THREE     2'h2

// Divider exponents for clock source codes 000 to 101
`define CTCI_EXP_CK0       4'hb
`define CTCI_EXP_CK1       4'h7
`define CTCI_EXP_CK2       4'h5
`define CTCI_EXP_CK3       4'h3
`define CTCI_EXP_CK4       4'h2
`define CTCI_EXP_CK5       4'h1

`endif

// ===== pkg/ctci_pkg.sv
// Types shared by the compare timer design files
package ctci_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WAIT  = 3'b010,
    ST_COUNT = 3'b100
  } ctci_state_e;

  typedef logic [15:0] ctci_value_t;
  typedef logic [1:0]  ctci_ptr_t;

endpackage : ctci_pkg

// ===== src/ctci_sync.sv
// Two-flop synchroniser for the trigger and event pin
`timescale 1ns/1ps

module ctci_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);
  logic meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : ctci_sync

// ===== src/ctci_prescaler.sv
// Prescaler that turns the system clock into the selected count tick
`timescale 1ns/1ps
`include "ctci_params.svh"

module ctci_prescaler (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clear,
  input  wire logic [2:0] clock_select,
  input  wire logic       halve,
  output logic            tick
);
  logic [11:0] div_cnt;
  logic [3:0]  base_exp;
  logic [3:0]  exp_sel;
  logic [12:0] mask_full;
  logic        valid;

  always_comb begin
    valid    = 1'b1;
    base_exp = 4'h0;
    case (clock_select)
      3'h0: base_exp = `CTCI_EXP_CK0;
      3'h1: base_exp = `CTCI_EXP_CK1;
      3'h2: base_exp = `CTCI_EXP_CK2;
      3'h3: base_exp = `CTCI_EXP_CK3;
      3'h4: base_exp = `CTCI_EXP_CK4;
      3'h5: base_exp = `CTCI_EXP_CK5;
      default: valid = 1'b0;
    endcase
    exp_sel   = base_exp + {3'h0, halve};
    mask_full = (13'h0001 << exp_sel) - 13'h0001;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 12'h000;
    end else if (clear) begin
      div_cnt <= 12'h000;
    end else begin
      div_cnt <= div_cnt + 12'h001;
    end
  end

  // Registered so the tick is glitch free; codes 110 and 111 give no tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick <= 1'b0;
    end else begin
      tick <= valid && !clear && ((div_cnt & mask_full[11:0]) == mask_full[11:0]);
    end
  end

  tick_half_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && clock_select == 3'h5 && !halve && !clear) ##1 (!clear && clock_select == 3'h5 && !halve)
      |-> !tick ##1 tick)
    else $error("Divide by two tick spacing wrong");

endmodule : ctci_prescaler

// ===== src/ctci_top.sv
// Compare timer core: AHB-Lite registers, trigger logic, counter and pulse output
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "ctci_params.svh"

// What this block does
// - Soft reset bit always reads back as zero.
// - Run bit 0 stops and clears the counter; 1 starts counting.
// - Start source picks software or trigger start; trigger start unavailable for events.
// - Both-edge enable stops on the opposite edge, only with trigger start.
// - Edge select picks rising or falling pin edge for start and event counting.
// - Mode bit picks timer/event counting or pulse generator output.
// - Polarity bit gives forward or reversed pulse output after start.
// - Soft reset clears control fields, counter, state and pulse output, not the compare values or a pending interrupt.
// - Output flop init bit clears or sets the output flop.
// - Count field enables A, A and B, or A, B and C; 11 reserved.
// - Trigger disable makes the pin input read as logic 0.
// - Writes to B and C are ignored unless pulse mode enables them.
// - On match with the top value raise interrupt and clear; keep counting unless the cycle bit selects one-shot, which event counting ignores.
module ctci_top (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic [31:0]                 hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  input  wire logic                   trigger_event_pin,
  input  wire logic                   prescale_halve,
  output logic                        pulse_out,
  output logic                        compare_irq,
  output ctci_pkg::ctci_value_t       timer_count
);
  import ctci_pkg::*;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Bus data phase
  logic         dp_valid;
  logic         dp_write;
  logic [7:0]   dp_idx;
  logic         wr_ctrl1;
  logic         wr_ctrl2;
  logic         wr_cmp;
  logic         soft_rst;
  logic [31:0]  rd_value;
  logic         addr_ok;

  // Control fields
  logic         run_control;
  logic         start_source_select;
  logic         both_edge_enable;
  logic         trigger_edge_select;
  logic         cycle_select;
  logic         mode_select_bit;
  logic         pulse_polarity_select;
  logic         trigger_input_disable;
  logic [1:0]   compare_count_select;
  logic [2:0]   clock_source_select;
  logic         output_flop_init;

  // Timer state
  ctci_value_t  compare_value_a;
  ctci_value_t  compare_value_b;
  ctci_value_t  compare_value_c;
  ctci_ptr_t    wr_ptr;
  ctci_ptr_t    last_ptr;
  ctci_state_e  st;
  ctci_state_e  next_st;
  ctci_value_t  next_count;
  ctci_value_t  cnt_inc;
  ctci_value_t  cmp_top;
  logic         out_flop;
  logic         pin_sync;
  logic         pin_lvl;
  logic         pin_prev;
  logic         rise_edge;
  logic         fall_edge;
  logic         act_edge;
  logic         opp_edge;
  logic         pre_tick;
  logic         tick;
  logic         event_mode;
  logic         trig_mode;
  logic         en_b;
  logic         en_c;
  logic         counting;
  logic         cnt_restart;
  logic         hit_a;
  logic         hit_b;
  logic         hit_c;
  logic         top_hit;
  logic         oneshot_done;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_idx   <= 8'h00;
    end else if (hready) begin
      dp_valid <= hsel && htrans[1];
      dp_write <= hwrite;
      dp_idx   <= haddr[9:2];
    end
  end

  assign wr_ctrl1 = dp_valid && dp_write && dp_idx == `CTCI_IDX_CTRL_ONE;
  assign wr_ctrl2 = dp_valid && dp_write && dp_idx == `CTCI_IDX_CTRL_TWO;
  assign wr_cmp   = dp_valid && dp_write && dp_idx == `CTCI_IDX_COMPARE;
  assign soft_rst = wr_ctrl1 && hwdata[`CTCI_C1_SRES];

  // Compare registers and unmapped words read as zero
  always_comb begin
    rd_value = 32'h0000_0000;
    case (haddr[9:2])
      `CTCI_IDX_CTRL_ONE: rd_value[7:0] = {1'b0, pulse_polarity_select, mode_select_bit, cycle_select,
                                           trigger_edge_select, both_edge_enable, start_source_select,
                                           run_control};
      `CTCI_IDX_CTRL_TWO: rd_value[7:0] = {1'b0, trigger_input_disable, compare_count_select,
                                           clock_source_select, output_flop_init};
      `CTCI_IDX_STATUS: begin
        rd_value[31:`CTCI_ST_CNT_LO] = timer_count;
        rd_value[`CTCI_ST_FLOP]      = out_flop;
        rd_value[`CTCI_ST_RUNNING]   = st == ST_COUNT;
      end
      default: rd_value = 32'h0000_0000;
    endcase
  end

  // Read data is sampled in the address phase, so a read right behind a write sees the old value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= rd_value;
    end
  end

  // Control registers; a software write wins over the one-shot clearing of the run bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_control           <= `CTCI_CTRL_RST;
      start_source_select   <= `CTCI_CTRL_RST;
      both_edge_enable      <= `CTCI_CTRL_RST;
      trigger_edge_select   <= `CTCI_CTRL_RST;
      cycle_select          <= `CTCI_CTRL_RST;
      mode_select_bit       <= `CTCI_CTRL_RST;
      pulse_polarity_select <= `CTCI_CTRL_RST;
    end else if (soft_rst) begin
      run_control           <= `CTCI_CTRL_RST;
      start_source_select   <= `CTCI_CTRL_RST;
      both_edge_enable      <= `CTCI_CTRL_RST;
      trigger_edge_select   <= `CTCI_CTRL_RST;
      cycle_select          <= `CTCI_CTRL_RST;
      mode_select_bit       <= `CTCI_CTRL_RST;
      pulse_polarity_select <= `CTCI_CTRL_RST;
    end else if (wr_ctrl1) begin
      run_control           <= hwdata[`CTCI_C1_RUN];
      start_source_select   <= hwdata[`CTCI_C1_SSRC];
      both_edge_enable      <= hwdata[`CTCI_C1_BOTH];
      trigger_edge_select   <= hwdata[`CTCI_C1_EDGE];
      cycle_select          <= hwdata[`CTCI_C1_CYCLE];
      mode_select_bit       <= hwdata[`CTCI_C1_MODE];
      pulse_polarity_select <= hwdata[`CTCI_C1_POL];
    end else if (oneshot_done && !trig_mode) begin
      run_control           <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trigger_input_disable <= `CTCI_CTRL_RST;
      compare_count_select  <= `CTCI_CNT_SEL_RST;
      clock_source_select   <= `CTCI_CLK_RST;
      output_flop_init      <= `CTCI_CTRL_RST;
    end else if (soft_rst) begin
      trigger_input_disable <= `CTCI_CTRL_RST;
      compare_count_select  <= `CTCI_CNT_SEL_RST;
      clock_source_select   <= `CTCI_CLK_RST;
      output_flop_init      <= `CTCI_CTRL_RST;
    end else if (wr_ctrl2) begin
      trigger_input_disable <= hwdata[`CTCI_C2_TDIS];
      compare_count_select  <= hwdata[`CTCI_C2_CNT_HI:`CTCI_C2_CNT_LO];
      clock_source_select   <= hwdata[`CTCI_C2_CLK_HI:`CTCI_C2_CLK_LO];
      output_flop_init      <= hwdata[`CTCI_C2_FFINIT];
    end
  end

  // Compare loading through one shared address
  assign en_b     = mode_select_bit && (compare_count_select == `CTCI_CNT_TWO ||
                                        compare_count_select == `CTCI_CNT_THREE);
  assign en_c     = mode_select_bit && compare_count_select == `CTCI_CNT_THREE;
  assign last_ptr = en_c ? 2'h2 : (en_b ? 2'h1 : 2'h0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_value_a <= `CTCI_COMPARE_RST;
      compare_value_b <= `CTCI_COMPARE_RST;
      compare_value_c <= `CTCI_COMPARE_RST;
    end else if (wr_cmp) begin
      case (wr_ptr)
        2'h0: compare_value_a <= hwdata[15:0];
        2'h1: if (en_b) compare_value_b <= hwdata[15:0];
        2'h2: if (en_c) compare_value_c <= hwdata[15:0];
        default: compare_value_a <= compare_value_a;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr <= 2'h0;
    end else if (soft_rst || wr_ctrl2) begin
      wr_ptr <= 2'h0;
    end else if (wr_cmp) begin
      wr_ptr <= (wr_ptr >= last_ptr) ? 2'h0 : wr_ptr + 2'h1;
    end
  end

  // Pin input: synchronised, then gated by the disable bit
  ctci_sync u_pin_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     (trigger_event_pin),
    .q     (pin_sync)
  );

  assign pin_lvl = pin_sync && !trigger_input_disable;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_prev <= 1'b0;
    end else begin
      pin_prev <= pin_lvl;
    end
  end

  assign rise_edge = pin_lvl && !pin_prev;
  assign fall_edge = !pin_lvl && pin_prev;
  assign act_edge  = trigger_edge_select ? fall_edge : rise_edge;
  assign opp_edge  = trigger_edge_select ? rise_edge : fall_edge;

  ctci_prescaler u_prescaler (
    .clk          (hclk),
    .rst_n        (hresetn),
    .clear        (soft_rst || st == ST_IDLE),
    .clock_select (clock_source_select),
    .halve        (prescale_halve),
    .tick         (pre_tick)
  );

  // Event counting and trigger start exclude each other
  assign event_mode   = !mode_select_bit && clock_source_select == `CTCI_CLK_EVENT;
  assign trig_mode    = start_source_select && !event_mode;
  assign tick         = (clock_source_select == `CTCI_CLK_EVENT) ? act_edge : pre_tick;
  assign cnt_inc      = timer_count + 16'h0001;
  assign cmp_top      = en_c ? compare_value_c : (en_b ? compare_value_b : compare_value_a);
  assign counting     = st == ST_COUNT && run_control;
  assign cnt_restart  = trig_mode && (act_edge || (both_edge_enable && opp_edge));
  assign hit_a        = tick && cnt_inc == compare_value_a;
  assign hit_b        = tick && en_b && cnt_inc == compare_value_b;
  assign hit_c        = tick && en_c && cnt_inc == compare_value_c;
  assign top_hit      = counting && !cnt_restart && tick && cnt_inc == cmp_top;
  assign oneshot_done = top_hit && cycle_select && !event_mode;

  always_comb begin
    next_st    = st;
    next_count = timer_count;
    if (!run_control) begin
      next_st    = ST_IDLE;
      next_count = `CTCI_COUNT_RST;
    end else begin
      case (st)
        ST_IDLE: begin
          next_st    = trig_mode ? ST_WAIT : ST_COUNT;
          next_count = `CTCI_COUNT_RST;
        end
        ST_WAIT: begin
          if (act_edge) next_st = ST_COUNT;
          next_count = `CTCI_COUNT_RST;
        end
        ST_COUNT: begin
          if (trig_mode && both_edge_enable && opp_edge) begin
            next_st    = ST_WAIT;
            next_count = `CTCI_COUNT_RST;
          end else if (trig_mode && act_edge) begin
            next_count = `CTCI_COUNT_RST;
          end else if (top_hit) begin
            next_count = `CTCI_COUNT_RST;
            if (oneshot_done) next_st = trig_mode ? ST_WAIT : ST_IDLE;
          end else if (tick) begin
            next_count = cnt_inc;
          end
        end
        default: begin
          next_st    = ST_IDLE;
          next_count = `CTCI_COUNT_RST;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st          <= ST_IDLE;
      timer_count <= `CTCI_COUNT_RST;
    end else if (soft_rst) begin
      st          <= ST_IDLE;
      timer_count <= `CTCI_COUNT_RST;
    end else begin
      st          <= next_st;
      timer_count <= next_count;
    end
  end

  // Output flop toggles on every enabled compare match in pulse mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_flop <= 1'b0;
    end else if (soft_rst) begin
      out_flop <= 1'b0;
    end else if (wr_ctrl2) begin
      out_flop <= hwdata[`CTCI_C2_FFINIT];
    end else if (mode_select_bit && counting && !cnt_restart && (hit_a || hit_b || hit_c)) begin
      out_flop <= !out_flop;
    end
  end

  // One cycle behind the flop; registered so the output is glitch free
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_out <= 1'b0;
    end else if (soft_rst) begin
      pulse_out <= 1'b0;
    end else begin
      pulse_out <= out_flop ^ pulse_polarity_select;
    end
  end

  // Soft reset deliberately does not touch a pending interrupt pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_irq <= 1'b0;
    end else begin
      compare_irq <= top_hit;
    end
  end

  sequence s_wait_rise;
    st == ST_WAIT && run_control && trig_mode && !trigger_edge_select && !soft_rst && rise_edge;
  endsequence

  sequence s_count_top;
    counting && !soft_rst && !cnt_restart && tick && cnt_inc == cmp_top && !cycle_select;
  endsequence

  soft_bit_zero_a: assert property (
    (dp_valid && !dp_write && dp_idx == `CTCI_IDX_CTRL_ONE) |-> hrdata[`CTCI_C1_SRES] == 1'b0)
    else $error("Soft reset bit read back as one");

  stop_clears_a: assert property (
    ($fell(run_control) && !soft_rst) |=> (st == ST_IDLE && timer_count == 16'h0000))
    else $error("Counter not stopped and cleared after run bit fell");

  trig_arm_a: assert property (
    (st == ST_IDLE && run_control && trig_mode && !soft_rst) |=> st == ST_WAIT)
    else $error("Trigger start did not wait for an edge");

  both_stop_a: assert property (
    (counting && trig_mode && both_edge_enable && opp_edge && !soft_rst)
      |=> (st == ST_WAIT && timer_count == 16'h0000))
    else $error("Opposite edge did not stop the counter");

  edge_start_a: assert property (
    s_wait_rise |=> st == ST_COUNT ##1 (timer_count <= 16'h0001 || !counting))
    else $error("Rising edge did not start the counter");

  top_match_a: assert property (
    s_count_top |=> (compare_irq && timer_count == 16'h0000 && st == ST_COUNT))
    else $error("Compare match did not raise interrupt and clear");

  ppg_toggle_a: assert property (
    (mode_select_bit && counting && !cnt_restart && hit_a && !soft_rst && !wr_ctrl2)
      |=> out_flop != $past(out_flop))
    else $error("Output flop did not toggle on match");

  soft_clear_a: assert property (
    soft_rst |=> (st == ST_IDLE && !run_control && !out_flop) ##1 !pulse_out)
    else $error("Soft reset left timer state set");

  irq_kept_a: assert property (
    (soft_rst && top_hit) |=> compare_irq)
    else $error("Soft reset lost an interrupt");

  flop_init_a: assert property (
    (wr_ctrl2 && !soft_rst) |=> out_flop == $past(hwdata[`CTCI_C2_FFINIT]))
    else $error("Output flop not loaded from init bit");

  gate_bc_a: assert property (
    (wr_cmp && !mode_select_bit) |=> ($stable(compare_value_b) && $stable(compare_value_c)))
    else $error("Compare B or C written outside pulse mode");

  pin_gate_a: assert property (
    trigger_input_disable [*2] |-> !rise_edge)
    else $error("Disabled trigger input produced an edge");

  oneshot_stop_a: assert property (
    (oneshot_done && !trig_mode && !wr_ctrl1) |=> (!run_control && st == ST_IDLE))
    else $error("One-shot did not stop the timer");

endmodule : ctci_top

// ===== test/ctci_pin_src.sv
// Partner model: pulse source on the trigger and event pin
`timescale 1ns/1ps

module ctci_pin_src (
  output logic pin
);
  initial pin = 1'b0;

  // Each level lasts four clocks, well above the one clock the pin logic needs to see a level
  task automatic pulse();
    pin = 1'b1;
    #100;
    pin = 1'b0;
    #100;
  endtask : pulse
endmodule : ctci_pin_src

// ===== test/ctci_top_tb.sv
// Self-checking bench for the compare timer core
`timescale 1ns/1ps
`include "ctci_params.svh"

module ctci_top_tb;
  import ctci_pkg::*;
  localparam logic [7:0] C1 = `CTCI_IDX_CTRL_ONE;
  localparam logic [7:0] C2 = `CTCI_IDX_CTRL_TWO;
  localparam logic [7:0] CV = `CTCI_IDX_COMPARE;
  logic        hclk, hresetn, hsel, hwrite, prescale_halve;
  logic [31:0] haddr, hwdata, rv;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, pulse_out, compare_irq;
  wire         pin;
  ctci_value_t timer_count;
  int          n_mismatch, checks;

  ctci_top ctci_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .trigger_event_pin(pin), .prescale_halve(prescale_halve),
    .pulse_out(pulse_out), .compare_irq(compare_irq), .timer_count(timer_count));
  ctci_pin_src ctci_pin_src_inst (.pin(pin));

  always #12.5 hclk = ~hclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask : bus

  // Cycles from one compare interrupt to the next
  task automatic period(input int exp);
    int n;
    n = 0;
    do begin @(negedge hclk); n++; end while (compare_irq !== 1'b1 && n < 300);
    n = 0;
    do begin @(negedge hclk); n++; end while (compare_irq !== 1'b1 && n < 300);
    chk(n, exp, "irq period");
  endtask : period

  task automatic setup(input logic [31:0] c2, input logic [31:0] a);
    bus(1'b1, C1, 32'h0);
    bus(1'b1, C2, c2);
    bus(1'b1, CV, a);
  endtask : setup

  task automatic t_regs();
    bus(1'b0, C1, 32'h0);
    chk(rv, 32'h0, "ctrl1 reset");
    bus(1'b0, C2, 32'h0);
    chk(rv, 32'h0, "ctrl2 reset");
    bus(1'b0, CV, 32'h0);
    chk(rv, 32'h0, "compare read");
    bus(1'b0, 8'h20, 32'h0);
    chk(rv, 32'h0, "unmapped read");
    bus(1'b1, C1, 32'h60);
    bus(1'b0, C1, 32'h0);
    chk(rv, 32'h60, "ctrl1 rw");
    bus(1'b1, C1, 32'he0);
    bus(1'b0, C1, 32'h0);
    chk(rv, 32'h0, "soft reset reads 0");
  endtask : t_regs

  // Software start, clock code 101, top 3: three ticks of 2 or 4 clocks
  task automatic t_timer();
    for (int h = 0; h < 2; h++) begin
      setup(32'h0a, 32'h3);
      prescale_halve <= h[0];
      bus(1'b1, C1, 32'h01);
      period(6 << h);
    end
    bus(1'b1, C1, 32'h0);
    // The counter is cleared one edge after the run bit falls
    repeat (2) @(negedge hclk);
    chk(timer_count, 16'h0, "stop clears");
    prescale_halve <= 1'b0;
  endtask : t_timer

  task automatic t_trig();
    setup(32'h0a, 32'h3);
    bus(1'b1, C1, 32'h03);
    repeat (20) @(negedge hclk);
    chk(timer_count, 16'h0, "waits for trigger");
    ctci_pin_src_inst.pulse();
    period(6);
    bus(1'b1, C1, 32'h0);
    bus(1'b1, C1, 32'h07);
    ctci_pin_src_inst.pulse();
    // The falling edge must have sent the counter back to waiting, cleared
    bus(1'b0, `CTCI_IDX_STATUS, 32'h0);
    chk(rv, 32'h0, "both-edge stop");
  endtask : t_trig

  // One-shot software start: the run bit drops by itself at the first match
  task automatic t_oneshot();
    int n;
    setup(32'h0a, 32'h3);
    bus(1'b1, C1, 32'h11);
    n = 0;
    while (compare_irq !== 1'b1 && n < 100) begin @(negedge hclk); n++; end
    chk(compare_irq, 1'b1, "one-shot irq");
    bus(1'b0, C1, 32'h0);
    chk(rv, 32'h10, "one-shot run cleared");
  endtask : t_oneshot

  // Event counting on falling edges; then the same with the pin disabled
  task automatic t_event(input logic [31:0] c2, input logic [15:0] exp);
    setup(c2, 32'h9);
    bus(1'b1, C1, 32'h09);
    repeat (2) ctci_pin_src_inst.pulse();
    repeat (6) @(negedge hclk);
    chk(timer_count, exp, "event count");
  endtask : t_event

  // Pulse mode with A and B: B is written while idle, once pulse mode is set; top is B
  task automatic t_ppg();
    int n;
    setup(32'h1a, 32'h4);
    bus(1'b1, C1, 32'h20);
    bus(1'b1, CV, 32'h4);
    bus(1'b1, CV, 32'h8);
    bus(1'b1, C1, 32'h21);
    period(16);
    n = 0;
    while (pulse_out !== 1'b1 && n < 40) begin @(negedge hclk); n++; end
    chk(pulse_out, 1'b1, "pulse high");
    bus(1'b1, C1, 32'h80);
    repeat (2) @(negedge hclk);
    chk(pulse_out, 1'b0, "soft reset out");
    chk(timer_count, 16'h0, "soft reset count");
    bus(1'b0, C2, 32'h0);
    chk(rv, 32'h0, "soft reset ctrl2");
  endtask : t_ppg

  task automatic finish_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    {hsel, hwrite, prescale_halve} = 3'h0;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    n_mismatch = 0;
    checks = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_timer();
    t_trig();
    t_oneshot();
    t_event(32'h0e, 16'h2);
    t_event(32'h4e, 16'h0);
    t_ppg();
    finish_test();
  end

  // Whole run needs well under 3000 cycles
  initial begin
    #250000;
    n_mismatch++;
    finish_test();
  end
endmodule : ctci_top_tb
